// File: rtl/tivc_pkg.sv
// Package of constants and types for the time interval counter
package tivc_pkg;
   // Special-function register addresses
   localparam logic [7:0] ADDR_CTRL = 8'hA1;
   localparam logic [7:0] ADDR_SUB = 8'hA2;
   localparam logic [7:0] ADDR_SEC = 8'hA3;
   localparam logic [7:0] ADDR_MIN = 8'hA4;
   localparam logic [7:0] ADDR_HOUR = 8'hA5;
   localparam logic [7:0] ADDR_TARGET = 8'hA6;

   // Bit positions in interval_control
   localparam int CTRL_TIMEBASE_EN = 0;
   localparam int CTRL_INTERVAL_EN = 1;
   localparam int CTRL_MATCH_FLAG = 2;
   localparam int CTRL_SINGLE_SHOT = 3;
   localparam int CTRL_SEL_LO = 4;
   localparam int CTRL_SEL_HI = 5;
   localparam int CTRL_FUTURE = 6;

   // Last value of each time-keeping counter before it wraps, then the byte constants zero and one
   localparam logic [7:0] MAX_SUB = 8'h7F;
   localparam logic [7:0] MAX_SEC = 8'h3B;
   localparam logic [7:0] MAX_MIN = 8'h3B;
   localparam logic [7:0] MAX_HOUR = 8'h17;
   localparam logic [7:0] ZERO8 = 8'h00;
   localparam logic [7:0] ONE8 = 8'h01;

   // Time base selection codes
   localparam logic [1:0] TB_TICK = 2'h0;
   localparam logic [1:0] TB_SEC = 2'h1;
   localparam logic [1:0] TB_MIN = 2'h2;
   localparam logic [1:0] TB_HOUR = 2'h3;

   // 1/128 second expressed in ns, and the system clock period
   localparam int unsigned TICK_PERIOD_NS = 7812500;
   localparam int unsigned CLK_PERIOD_NS = 10;
   localparam int unsigned TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;
   localparam int TICK_CNT_W = 20;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } tivc_sfr_req_s;

   typedef struct packed {
      logic [TICK_CNT_W-1:0] cnt;
      logic tick;
   } tivc_div_state_s;

   typedef struct packed {
      logic [7:0] sub;
      logic [7:0] sec;
      logic [7:0] min;
      logic [7:0] hour;
      logic [7:0] target;
      logic [7:0] ic;
      logic future;
      logic [1:0] sel;
      logic single;
      logic flag;
      logic ien;
      logic timebase_enable;
      logic irq;
      logic [7:0] rdata;
   } tivc_state_s;
endpackage

// File: rtl/tivc_tick_gen.sv
// Divider that makes the 1/128 second tick enable from the system clock
`timescale 1ns/1ps
module tivc_tick_gen #(
   parameter int unsigned CYCLES = tivc_pkg::TICK_CYCLES
) (
   input wire logic clk_sys,
   input wire logic sys_rst,
   input wire logic run,
   output logic tick
);
   import tivc_pkg::*;

   localparam logic [TICK_CNT_W-1:0] LAST = TICK_CNT_W'(CYCLES - 1);

   tivc_div_state_s q;
   tivc_div_state_s d;

   // Held at zero while stopped so the first tick after enable is a full one
   always_comb
   begin
      d = q;
      d.tick = 1'b0;
      if (!run)
      begin
         d.cnt = '0;
      end
      else if (q.cnt == LAST)
      begin
         d.cnt = '0;
         d.tick = 1'b1;
      end
      else
      begin
         d.cnt = q.cnt + TICK_CNT_W'(1);
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
      begin
         q <= '0;
      end
      else
      begin
         q <= d;
      end
   end

   assign tick = q.tick;

   tick_period_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
      q.tick |-> $past(run) && $past(q.cnt) == LAST)
      else $error("tick period broken");
endmodule

// File: rtl/tivc_top.sv
// Time interval counter with real-time clock registers on the SFR port
`timescale 1ns/1ps
module tivc_top #(
   parameter int unsigned TICK_CYCLES = tivc_pkg::TICK_CYCLES
) (
   input wire logic clk_sys,
   input wire logic sys_rst,
   input wire tivc_pkg::tivc_sfr_req_s sfr_req,
   input wire logic int_enable,
   output logic [7:0] sfr_rdata,
   output logic irq
);
   import tivc_pkg::*;

   tivc_state_s q;
   tivc_state_s d;
   logic tick;
   logic tick_on;
   logic sub_wrap;
   logic sec_wrap;
   logic min_wrap;
   logic step;
   logic [7:0] ic_next;
   logic ctrl_wr;
   logic time_wr_ok;

   // Own divider of the core clock stands in for the crystal tick, so
   // the tick rate depends on the core clock rate
   tivc_tick_gen #(
      .CYCLES(TICK_CYCLES)
   ) u_tick (
      .clk_sys(clk_sys),
      .sys_rst(sys_rst),
      .run(q.timebase_enable),
      .tick(tick)
   );

   assign ctrl_wr = sfr_req.wr && sfr_req.addr == ADDR_CTRL;
   assign time_wr_ok = sfr_req.wr && !q.timebase_enable;
   assign tick_on = tick && q.timebase_enable;
   assign sub_wrap = tick_on && q.sub == MAX_SUB;
   assign sec_wrap = sub_wrap && q.sec == MAX_SEC;
   assign min_wrap = sec_wrap && q.min == MAX_MIN;
   assign ic_next = q.ic + ONE8;

   // Step on each increment of the chosen time register
   always_comb
   begin
      case (q.sel)
         TB_TICK: step = tick_on;
         TB_SEC: step = sub_wrap;
         TB_MIN: step = sec_wrap;
         TB_HOUR: step = min_wrap;
         default: step = 1'b0;
      endcase
   end

   always_comb
   begin
      d = q;
      // Software writes
      if (time_wr_ok && sfr_req.addr == ADDR_SUB)
      begin
         d.sub = sfr_req.wdata;
      end
      if (time_wr_ok && sfr_req.addr == ADDR_SEC)
      begin
         d.sec = sfr_req.wdata;
      end
      if (time_wr_ok && sfr_req.addr == ADDR_MIN)
      begin
         d.min = sfr_req.wdata;
      end
      if (time_wr_ok && sfr_req.addr == ADDR_HOUR)
      begin
         d.hour = sfr_req.wdata;
      end
      if (sfr_req.wr && sfr_req.addr == ADDR_TARGET)
      begin
         d.target = sfr_req.wdata;
      end
      if (ctrl_wr)
      begin
         d.timebase_enable = sfr_req.wdata[CTRL_TIMEBASE_EN];
         d.ien = sfr_req.wdata[CTRL_INTERVAL_EN];
         d.flag = sfr_req.wdata[CTRL_MATCH_FLAG];
         d.single = sfr_req.wdata[CTRL_SINGLE_SHOT];
         d.sel = {sfr_req.wdata[CTRL_SEL_HI], sfr_req.wdata[CTRL_SEL_LO]};
         d.future = sfr_req.wdata[CTRL_FUTURE];
      end
      // Cascaded time keeping; writes and ticks never meet since
      // writes need the time base off
      if (tick_on)
      begin
         d.sub = sub_wrap ? ZERO8 : q.sub + ONE8;
      end
      if (sub_wrap)
      begin
         d.sec = sec_wrap ? ZERO8 : q.sec + ONE8;
      end
      if (sec_wrap)
      begin
         d.min = min_wrap ? ZERO8 : q.min + ONE8;
      end
      if (min_wrap)
      begin
         d.hour = (q.hour == MAX_HOUR) ? ZERO8 : q.hour + ONE8;
      end
      // Interval counter; placed after writes so a hardware set of the
      // flag beats a software clear in the same cycle
      if (q.ien && step)
      begin
         if (ic_next == q.target)
         begin
            d.flag = 1'b1;
            d.ic = ZERO8;
            if (q.single)
            begin
               d.ien = 1'b0;
            end
         end
         else
         begin
            d.ic = ic_next;
         end
      end
      if (!d.ien)
      begin
         d.ic = ZERO8;
      end
      // Each control write that leaves the time base off clears, even if it was
      // off already; testing the level alone would wipe every load made while it is off
      if (ctrl_wr && !d.timebase_enable)
      begin
         d.sub = ZERO8;
         d.sec = ZERO8;
         d.min = ZERO8;
         d.hour = ZERO8;
      end
      d.irq = q.flag && int_enable;
      if (sfr_req.rd)
      begin
         case (sfr_req.addr)
            ADDR_CTRL: d.rdata = {1'b0, q.future, q.sel, q.single, q.flag,
                                  q.ien, q.timebase_enable};
            ADDR_SUB: d.rdata = q.sub;
            ADDR_SEC: d.rdata = q.sec;
            ADDR_MIN: d.rdata = q.min;
            ADDR_HOUR: d.rdata = q.hour;
            ADDR_TARGET: d.rdata = q.target;
            default: d.rdata = ZERO8;
         endcase
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
      begin
         q <= '0;
      end
      else
      begin
         q <= d;
      end
   end

   assign sfr_rdata = q.rdata;
   assign irq = q.irq;

   sub_count_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
      tick_on && q.sub != MAX_SUB && !ctrl_wr
      |=> q.sub == $past(q.sub) + ONE8)
      else $error("sub-second did not advance");

   sec_carry_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
      sub_wrap && q.sec == MAX_SEC && !ctrl_wr
      |=> q.sec == ZERO8 && q.sub == ZERO8)
      else $error("seconds did not wrap");

   min_carry_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
      sec_wrap && q.min != MAX_MIN && !ctrl_wr
      |=> q.min == $past(q.min) + ONE8)
      else $error("minutes did not advance");

   hour_wrap_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
      min_wrap && q.hour == MAX_HOUR && !ctrl_wr |=> q.hour == ZERO8)
      else $error("hours did not wrap");

   time_clear_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
      ctrl_wr && !sfr_req.wdata[CTRL_TIMEBASE_EN]
      |=> {q.sub, q.sec, q.min, q.hour} == '0
      ##1 ({q.sub, q.sec, q.min, q.hour} == '0 || $past(time_wr_ok)))
      else $error("time registers not cleared");

   time_load_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
      !q.timebase_enable && sfr_req.wr && sfr_req.addr == ADDR_SEC && !ctrl_wr
      |=> q.sec == $past(sfr_req.wdata))
      else $error("time register write lost");

   single_stop_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
      q.ien && step && ic_next == q.target && q.single && !ctrl_wr
      |=> !q.ien && q.flag && q.ic == ZERO8)
      else $error("single shot did not stop");

   reload_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
      q.ien && step && ic_next == q.target && !q.single && !ctrl_wr
      |=> q.ien && q.flag && q.ic == ZERO8)
      else $error("auto reload failed");

   hold_count_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
      q.ien && !step && !ctrl_wr |=> $stable(q.ic))
      else $error("interval counter moved without step");

   flag_sticky_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
      q.flag && !ctrl_wr |=> q.flag)
      else $error("match flag dropped by hardware");

   count_zero_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
      !q.ien |-> q.ic == ZERO8)
      else $error("disabled interval counter not zero");

   irq_req_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
      q.flag && int_enable
      |=> irq ##1 (irq || !$past(q.flag) || !$past(int_enable)))
      else $error("interrupt request missing");
endmodule

// File: verification/tivc_testbench.sv
// Self-checking testbench for the time interval counter
`timescale 1ns/1ps
module testbench;
   import tivc_pkg::*;
   // Short tick so that carries and matches fit in a brief run
   localparam int unsigned N = 8;
   logic clk_sys = 1'b0;
   logic sys_rst = 1'b1;
   tivc_sfr_req_s sfr_req = '0;
   logic int_enable = 1'b0;
   logic [7:0] sfr_rdata;
   logic irq;
   logic rd_seen = 1'b0;
   logic [8:0] exp_q[$];
   logic [8:0] exp_v;
   logic [31:0] rng = 32'h0000_F630;
   logic [1:0] s;
   logic [7:0] ctl_v;
   int bad_count = 0;
   int checks_done = 0;

   always #5 clk_sys = ~clk_sys;

   tivc_top #(.TICK_CYCLES(N)) i_dut (
      .clk_sys(clk_sys),
      .sys_rst(sys_rst),
      .sfr_req(sfr_req),
      .int_enable(int_enable),
      .sfr_rdata(sfr_rdata),
      .irq(irq)
   );

   function automatic logic [31:0] xs(input logic [31:0] x);
      x = x ^ (x << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction

   task automatic cyc(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask

   // One strobe per cycle; the struct is assigned once so back to back is safe
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      sfr_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      cyc(1);
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] d, input logic i);
      exp_q.push_back({i, d});
      sfr_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
      cyc(1);
   endtask

   task automatic idle(input int n);
      sfr_req = '0;
      cyc(n);
   endtask

   task automatic results();
      if (bad_count == 0 && checks_done > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   // Read data shows one cycle after the read edge; irq is checked with it
   always @(posedge clk_sys)
   begin
      if (rd_seen)
      begin
         checks_done++;
         exp_v = exp_q.pop_front();
         if ({irq, sfr_rdata} !== exp_v)
         begin
            bad_count++;
            $display("ERROR %0t: got %b/%h want %h", $time, irq, sfr_rdata,
                     exp_v);
         end
      end
      rd_seen <= sfr_req.rd;
   end

   initial
   begin
      repeat (20000) @(posedge clk_sys);
      bad_count++;
      $display("ERROR %0t: run did not finish", $time);
      results();
   end

   initial
   begin
      cyc(5);
      sys_rst = 1'b0;
      int_enable = 1'b1;
      for (int a = 8'hA0; a <= 8'hA7; a++)
         rd(8'(a), 8'h00, 1'b0);
      wr(ADDR_SUB, MAX_SUB);
      wr(ADDR_SEC, MAX_SEC);
      wr(ADDR_MIN, MAX_MIN);
      wr(ADDR_HOUR, MAX_HOUR);
      rd(ADDR_SUB, MAX_SUB, 1'b0);
      rd(ADDR_HOUR, MAX_HOUR, 1'b0);
      // One tick must carry through every stage to all zeros
      wr(ADDR_CTRL, 8'h41);
      idle(10);
      wr(ADDR_SEC, 8'h05);
      rd(ADDR_HOUR, ZERO8, 1'b0);
      rd(ADDR_MIN, ZERO8, 1'b0);
      rd(ADDR_SEC, ZERO8, 1'b0);
      rd(ADDR_SUB, ZERO8, 1'b0);
      idle(40);
      wr(ADDR_CTRL, 8'h40);
      rd(ADDR_SUB, ZERO8, 1'b0);
      // Auto-reload with a target of three ticks
      wr(ADDR_TARGET, 8'h03);
      wr(ADDR_CTRL, 8'h43);
      idle(29);
      rd(ADDR_CTRL, 8'h47, 1'b1);
      wr(ADDR_CTRL, 8'h43);
      rd(ADDR_CTRL, 8'h43, 1'b0);
      idle(23);
      rd(ADDR_CTRL, 8'h47, 1'b1);
      int_enable = 1'b0;
      idle(2);
      rd(ADDR_CTRL, 8'h47, 1'b0);
      wr(ADDR_CTRL, 8'h40);
      int_enable = 1'b1;
      // Each selection steps on the carry into its own register, the tick selection on every tick
      for (int k = 0; k < 4; k++)
      begin
         s = 2'(k);
         wr(ADDR_SUB, MAX_SUB - ONE8);
         wr(ADDR_SEC, (s >= TB_MIN) ? MAX_SEC : ZERO8);
         wr(ADDR_MIN, (s == TB_HOUR) ? MAX_MIN : ZERO8);
         wr(ADDR_TARGET, ONE8);
         ctl_v = 8'h4B | {2'b00, s, 4'h0};
         wr(ADDR_CTRL, ctl_v);
         idle(13);
         // Only the plain tick may step before the sub-second wrap;
         // xor 06 shows the flag set and the interval enable dropped
         rd(ADDR_CTRL, (k == 0) ? ctl_v ^ 8'h06 : ctl_v, k == 0);
         idle(7);
         rd(ADDR_CTRL, ctl_v ^ 8'h06, 1'b1);
         wr(ADDR_CTRL, 8'h40);
      end
      wr(ADDR_CTRL, 8'hC0);
      rd(ADDR_CTRL, 8'h40, 1'b0);
      wr(ADDR_CTRL, 8'h40);
      wr(8'hA7, 8'h55);
      rd(8'hA7, ZERO8, 1'b0);
      for (int k = 0; k < 8; k++)
      begin
         rng = xs(rng);
         wr(ADDR_TARGET, rng[7:0]);
         rd(ADDR_TARGET, rng[7:0], 1'b0);
      end
      // Reset in mid-run must clear target and control again
      wr(ADDR_TARGET, 8'h5A);
      wr(ADDR_CTRL, 8'h43);
      sys_rst = 1'b1;
      idle(2);
      sys_rst = 1'b0;
      rd(ADDR_TARGET, ZERO8, 1'b0);
      rd(ADDR_CTRL, ZERO8, 1'b0);
      idle(3);
      if (exp_q.size() != 0)
      begin
         bad_count++;
         $display("ERROR %0t: reads left unanswered", $time);
      end
      results();
   end
endmodule
